/* design/wwds_defs.svh */
`ifndef WWDS_DEFS_SVH
`define WWDS_DEFS_SVH

// ****************************************************************
// time base
// ****************************************************************
`define WWDS_CLK_MHZ          200
// one tick per microsecond
`define WWDS_TICK_CYC         (`WWDS_CLK_MHZ)
// glitch filter, at least 100 ns in cycles (rounded up)
`define WWDS_FILT_NS          100
`define WWDS_FILT_CYC         ((`WWDS_FILT_NS * `WWDS_CLK_MHZ + 999) / 1000)

// ****************************************************************
// timing in microseconds
// ****************************************************************
`define WWDS_FAULT_PULSE_US   1000
`define WWDS_RESET_TIMEOUT_US 100000

// early and late limits per option, in microseconds (lower bounds)
`define WWDS_EARLY_A_US       1000
`define WWDS_EARLY_B_US       10000
`define WWDS_EARLY_C_US       10000
`define WWDS_EARLY_D_US       10000
`define WWDS_EARLY_E_US       10000
`define WWDS_EARLY_F_US       17000
`define WWDS_EARLY_G_US       29000
`define WWDS_EARLY_H_US       543000
`define WWDS_LATE_A_US        10000
`define WWDS_LATE_B_US        100000
`define WWDS_LATE_C_US        300000
`define WWDS_LATE_D_US        10000000
`define WWDS_LATE_E_US        60000
`define WWDS_LATE_F_US        47000
`define WWDS_LATE_G_US        82000
`define WWDS_LATE_H_US        1300000

`define WWDS_US_W             24

`endif

/* design/wwds_pkg.sv */
package wwds_pkg;

  // factory timing option
  typedef enum logic [2:0] {
    WWDS_OPT_A, WWDS_OPT_B, WWDS_OPT_C, WWDS_OPT_D,
    WWDS_OPT_E, WWDS_OPT_F, WWDS_OPT_G, WWDS_OPT_H
  } wwds_opt_t;

  // watchdog states
  typedef enum logic [1:0] {
    WWDS_HELD, WWDS_FIRST, WWDS_ARMED, WWDS_FAULT
  } wwds_state_t;

endpackage : wwds_pkg

/* design/wwds_filter.sv */
`timescale 1ns/1ps
`include "wwds_defs.svh"

module wwds_filter (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic raw,
  output logic      clean
);

  logic       sync_a;
  logic       sync_b;
  logic [4:0] run;

  // two-stage synchroniser, pins idle high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end else begin
      sync_a <= raw;
      sync_b <= sync_a;
    end
  end

  // accept a new level only after it is stable for the filter time
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      run   <= 5'h00;
      clean <= 1'b1;
    end else if (sync_b == clean) begin
      run <= 5'h00;
    end else if (run == 5'(`WWDS_FILT_CYC - 1)) begin
      run   <= 5'h00;
      clean <= sync_b;
    end else begin
      run <= run + 5'h01;
    end
  end

endmodule : wwds_filter

/* design/wwds_tick.sv */
`timescale 1ns/1ps
`include "wwds_defs.svh"

module wwds_tick #(
  parameter logic [7:0] TICK_DIV = 8'(`WWDS_TICK_CYC)
) (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      tick_us
);

  logic [7:0] div;

  // free-running one-microsecond enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div     <= 8'h00;
      tick_us <= 1'b0;
    end else if (div == TICK_DIV - 8'h01) begin
      div     <= 8'h00;
      tick_us <= 1'b1;
    end else begin
      div     <= div + 8'h01;
      tick_us <= 1'b0;
    end
  end

endmodule : wwds_tick

/* design/wwds_supervisor.sv */
// How it works
// - a kick falling edge before the early limit since the last accepted edge is a fast fault.
// - no kick falling edge within the late limit after the last accepted edge is a slow fault.
// - the first kick after reset or fault output returns high never gives a fast fault.
// - the interval counter clears on each accepted kick edge and when reset goes high.
// - a kick inside the window keeps the fault output high and restarts the interval.
// - a fault drives the fault output low for 1 ms, within 0.5 ms to 3 ms.
// - the fault output is never low while the reset output is low.
// - manual reset low asserts reset, holds the counter at zero and releases the fault output.
// - reset stays low at least 100 ms after manual reset returns high.
// - undervoltage asserts reset; release waits for supply good over the whole timeout.
// - kicks are ignored while reset or fault output is low.
// - the reset timeout lasts at least 100 ms.
`timescale 1ns/1ps
`include "wwds_defs.svh"

module wwds_supervisor #(
  parameter wwds_pkg::wwds_opt_t OPTION         = wwds_pkg::WWDS_OPT_A,
  parameter logic [23:0]         RESET_TIMEOUT  = 24'(`WWDS_RESET_TIMEOUT_US),
  parameter logic [23:0]         FAULT_PULSE    = 24'(`WWDS_FAULT_PULSE_US),
  parameter logic [7:0]          TICK_DIV       = 8'(`WWDS_TICK_CYC)
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic window_kick_input,
  input  wire logic manual_reset_input,
  input  wire logic undervoltage,
  output logic      system_reset_n,
  output logic      fault_pulse_output,
  output logic      fault_pulse_oe
);

  // ****************************************************************
  // limit selection
  // ****************************************************************
  logic [`WWDS_US_W-1:0] early_limit;
  logic [`WWDS_US_W-1:0] late_limit;

  // per-option limit lookup
  always_comb begin
    case (OPTION)
      wwds_pkg::WWDS_OPT_A: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_A_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_A_US);
      end
      wwds_pkg::WWDS_OPT_B: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_B_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_B_US);
      end
      wwds_pkg::WWDS_OPT_C: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_C_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_C_US);
      end
      wwds_pkg::WWDS_OPT_D: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_D_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_D_US);
      end
      wwds_pkg::WWDS_OPT_E: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_E_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_E_US);
      end
      wwds_pkg::WWDS_OPT_F: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_F_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_F_US);
      end
      wwds_pkg::WWDS_OPT_G: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_G_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_G_US);
      end
      default: begin
        early_limit = `WWDS_US_W'(`WWDS_EARLY_H_US);
        late_limit  = `WWDS_US_W'(`WWDS_LATE_H_US);
      end
    endcase
  end

  // ****************************************************************
  // time base and input filters
  // ****************************************************************
  logic tick_us;
  logic kick_clean;
  logic mr_clean;
  logic uv_a;
  logic uv_b;

  wwds_tick #(
    .TICK_DIV (TICK_DIV)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .tick_us (tick_us)
  );

  wwds_filter u_kick_filt (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (window_kick_input),
    .clean   (kick_clean)
  );

  wwds_filter u_mr_filt (
    .clk     (clk),
    .reset_n (reset_n),
    .raw     (manual_reset_input),
    .clean   (mr_clean)
  );

  // undervoltage level synchroniser, asserted at reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      uv_a <= 1'b1;
      uv_b <= 1'b1;
    end else begin
      uv_a <= undervoltage;
      uv_b <= uv_a;
    end
  end

  // ****************************************************************
  // reset supervision
  // ****************************************************************
  logic                  hold_reset;
  logic                  rst_done;
  logic [`WWDS_US_W-1:0] rst_count;

  // reset is held while supply is bad or manual reset is low
  assign hold_reset = uv_b | ~mr_clean;

  // last tick of the reset timeout
  assign rst_done = ~system_reset_n & tick_us &
                    (rst_count >= RESET_TIMEOUT - 24'h00_0001);

  // timeout counter, restarted whenever a hold condition returns
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_count <= '0;
    end else if (hold_reset) begin
      rst_count <= '0;
    end else if (!system_reset_n && tick_us && !rst_done) begin
      rst_count <= rst_count + 24'h00_0001;
    end
  end

  // reset output, released only once the full timeout has run
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      system_reset_n <= 1'b0;
    end else if (hold_reset) begin
      system_reset_n <= 1'b0;
    end else if (rst_done) begin
      system_reset_n <= 1'b1;
    end
  end

  // ****************************************************************
  // reset release edge
  // ****************************************************************
  logic rst_prev;
  logic rst_rise;

  // previous reset output level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_prev <= 1'b0;
    end else begin
      rst_prev <= system_reset_n;
    end
  end

  // one-cycle strobe as the reset output goes high
  assign rst_rise = system_reset_n & ~rst_prev;

  // ****************************************************************
  // watchdog window
  // ****************************************************************
  wwds_pkg::wwds_state_t state;
  logic                  kick_prev;
  logic                  kick_fall;
  logic                  watching;
  logic                  fast_fault;
  logic                  slow_fault;
  logic                  good_kick;
  logic                  pulse_done;
  logic [`WWDS_US_W-1:0] interval;
  logic [`WWDS_US_W-1:0] pulse_count;
  logic                  fault_low;

  // falling edge of the filtered kick
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kick_prev <= 1'b1;
    end else begin
      kick_prev <= kick_clean;
    end
  end

  assign kick_fall = kick_prev & ~kick_clean;

  // window events, judged only while reset is high and no fault stands; pulse end judged only during a fault
  assign watching   = system_reset_n &
                      (state == wwds_pkg::WWDS_FIRST || state == wwds_pkg::WWDS_ARMED);
  assign fast_fault = watching & kick_fall & (state == wwds_pkg::WWDS_ARMED) &
                      (interval < early_limit);
  assign good_kick  = watching & kick_fall & ~fast_fault;
  assign slow_fault = watching & ~kick_fall & tick_us &
                      (interval >= late_limit - 24'h00_0001);
  assign pulse_done = system_reset_n & (state == wwds_pkg::WWDS_FAULT) & tick_us &
                      (pulse_count >= FAULT_PULSE - 24'h00_0001);

  // window state machine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= wwds_pkg::WWDS_HELD;
    end else if (!system_reset_n) begin
      state <= wwds_pkg::WWDS_HELD;
    end else begin
      case (state)
        wwds_pkg::WWDS_HELD: begin
          state <= wwds_pkg::WWDS_FIRST;
        end
        wwds_pkg::WWDS_FIRST, wwds_pkg::WWDS_ARMED: begin
          if (fast_fault || slow_fault) begin
            state <= wwds_pkg::WWDS_FAULT;
          end else if (good_kick) begin
            state <= wwds_pkg::WWDS_ARMED;
          end
        end
        wwds_pkg::WWDS_FAULT: begin
          if (pulse_done) begin
            state <= wwds_pkg::WWDS_FIRST;
          end
        end
        default: begin
          state <= wwds_pkg::WWDS_HELD;
        end
      endcase
    end
  end

  // interval counter in microsecond ticks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      interval <= '0;
    end else if (!system_reset_n || rst_rise) begin
      interval <= '0;
    end else if (good_kick || state == wwds_pkg::WWDS_FAULT) begin
      interval <= '0;
    end else if (watching && tick_us && !slow_fault) begin
      interval <= interval + 24'h00_0001;
    end
  end

  // fault pulse length counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_count <= '0;
    end else if (!system_reset_n || state != wwds_pkg::WWDS_FAULT) begin
      pulse_count <= '0;
    end else if (tick_us && !pulse_done) begin
      pulse_count <= pulse_count + 24'h00_0001;
    end
  end

  // fault pin pull request, dropped at once by reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_low <= 1'b0;
    end else if (!system_reset_n) begin
      fault_low <= 1'b0;
    end else if (fast_fault || slow_fault) begin
      fault_low <= 1'b1;
    end else if (pulse_done) begin
      fault_low <= 1'b0;
    end
  end

  // ****************************************************************
  // fault pin
  // ****************************************************************
  // open-drain fault pin, only pulled low and only while reset is high
  assign fault_pulse_output = 1'b0;
  assign fault_pulse_oe     = fault_low & system_reset_n;

endmodule : wwds_supervisor

/* sim/wwds_chk.sv */
`timescale 1ns/1ps
`include "wwds_defs.svh"
module wwds_chk #(
  parameter logic [23:0] RESET_TIMEOUT = 24'h00_0032,
  parameter logic [23:0] FAULT_PULSE   = 24'h00_000A,
  parameter logic [7:0]  TICK_DIV      = 8'hC8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic window_kick_input,
  input wire logic manual_reset_input,
  input wire logic undervoltage,
  input wire logic system_reset_n,
  input wire logic fault_pulse_output,
  input wire logic fault_pulse_oe
);
  // ****************************************************************
  // helper counters, in clock cycles
  // ****************************************************************
  // cycles per tick; the late limit is that of option A, as the bench uses
  localparam int tick     = int'(TICK_DIV);
  localparam int hold_cyc = (int'(RESET_TIMEOUT) - 1) * tick;
  localparam int fp_cyc   = int'(FAULT_PULSE) * tick;
  localparam int late_cyc = `WWDS_LATE_A_US * tick;
  int   mr_lo, uv_hi, quiet, oe_len, gap;
  logic kick_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // gap restarts on any raw kick fall, while in reset and during a fault
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mr_lo  <= 0;
      uv_hi  <= 0;
      quiet  <= 0;
      oe_len <= 0;
      gap    <= 0;
      kick_d <= 1'b1;
    end else begin
      mr_lo  <= manual_reset_input ? 0 : mr_lo + 1;
      uv_hi  <= undervoltage ? uv_hi + 1 : 0;
      quiet  <= (manual_reset_input && !undervoltage) ? quiet + 1 : 0;
      oe_len <= fault_pulse_oe ? oe_len + 1 : 0;
      gap    <= (!system_reset_n || fault_pulse_oe || (kick_d && !window_kick_input)) ? 0 : gap + 1;
      kick_d <= window_kick_input;
    end
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_no_fault_reset: assert property (!system_reset_n |-> !fault_pulse_oe)
    else $error("fault output active during reset");
  a_od_data_low: assert property (!fault_pulse_output)
    else $error("open-drain fault data not low");
  a_mr_to_reset: assert property (mr_lo == 30 |-> !system_reset_n)
    else $error("manual reset did not assert reset");
  a_mr_drops_fault: assert property (mr_lo == 40 |-> !fault_pulse_oe)
    else $error("manual reset did not release fault output");
  a_uv_to_reset: assert property (uv_hi == 40 |-> !system_reset_n)
    else $error("undervoltage did not assert reset");
  a_reset_hold: assert property ($rose(system_reset_n) |-> quiet >= hold_cyc)
    else $error("reset released too early");
  a_pulse_len: assert property ($fell(fault_pulse_oe) && system_reset_n
    |-> oe_len inside {[fp_cyc - tick : fp_cyc + tick]})
    else $error("fault pulse length wrong");
  a_slow_due: assert property (gap == late_cyc + 100 |-> fault_pulse_oe)
    else $error("slow fault missing");
  a_no_win_fault: assert property ($rose(fault_pulse_oe)
    |-> gap < 400 || gap >= late_cyc - 200)
    else $error("fault raised inside window");
  a_glitch_reject: assert property (system_reset_n && $rose(manual_reset_input) && mr_lo <= 10
    |-> system_reset_n[*8] ##1 system_reset_n[*8])
    else $error("short manual reset glitch caused reset");
  c_fast: cover property ($rose(fault_pulse_oe) && gap < 400);
  c_slow: cover property ($rose(fault_pulse_oe) && gap > 400);
  c_release: cover property ($rose(system_reset_n));
endmodule : wwds_chk

bind wwds_supervisor wwds_chk #(
  .RESET_TIMEOUT(RESET_TIMEOUT),
  .FAULT_PULSE  (FAULT_PULSE),
  .TICK_DIV     (TICK_DIV)
) chk (
  .clk               (clk),
  .reset_n           (reset_n),
  .window_kick_input (window_kick_input),
  .manual_reset_input(manual_reset_input),
  .undervoltage      (undervoltage),
  .system_reset_n    (system_reset_n),
  .fault_pulse_output(fault_pulse_output),
  .fault_pulse_oe    (fault_pulse_oe)
);

/* sim/wwds_fw_model.sv */
`timescale 1ns/1ps
module wwds_fw_model (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic system_reset_n,
  input  wire logic kick_req,
  output logic      kick
);
  int lo;
  // firmware kick: line low for 400 ns, then high; no kicks while held in reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      kick <= 1'b1;
      lo   <= 0;
    end else if (kick_req && system_reset_n) begin
      kick <= 1'b0;
      lo   <= 80;
    end else if (lo > 1) begin
      lo <= lo - 1;
    end else begin
      kick <= 1'b1;
      lo   <= 0;
    end
  end
endmodule : wwds_fw_model

/* sim/wwds_supervisor_tb.sv */
`timescale 1ns/1ps
module wwds_supervisor_tb;
  logic clk, reset_n, mr, uv, kreq, kick, srst_n, fdat, foe, pin;
  int   bad_count, comparisons;
  // pull-up on the open-drain fault line
  assign pin = foe ? fdat : 1'b1;

  wwds_supervisor #(
    .OPTION       (wwds_pkg::WWDS_OPT_A),
    .RESET_TIMEOUT(24'h00_0032),
    .FAULT_PULSE  (24'h00_0064),
    .TICK_DIV     (8'h04)
  ) dut (
    .clk               (clk),
    .reset_n           (reset_n),
    .window_kick_input (kick),
    .manual_reset_input(mr),
    .undervoltage      (uv),
    .system_reset_n    (srst_n),
    .fault_pulse_output(fdat),
    .fault_pulse_oe    (foe)
  );
  wwds_fw_model fw (
    .clk           (clk),
    .reset_n       (reset_n),
    .system_reset_n(srst_n),
    .kick_req      (kreq),
    .kick          (kick)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input logic c, input string m);
    comparisons++;
    if (c !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic kick_now;
    kreq <= 1'b1;
    cyc(1);
    kreq <= 1'b0;
  endtask : kick_now
  // 4-cycle ticks: reset held through most of the 50 tick timeout, released soon after
  task automatic hold_chk;
    cyc(190);
    chk(srst_n === 1'b0, "reset released early");
    cyc(60);
    chk(srst_n === 1'b1, "reset not released");
  endtask : hold_chk
  task automatic report_and_stop;
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_window;
    kick_now();
    cyc(40);
    chk(foe === 1'b0, "first kick faulted");
    cyc(4400);
    kick_now();
    cyc(40);
    chk(foe === 1'b0, "kick in window faulted");
    cyc(500);
    kick_now();
    cyc(40);
    chk(foe === 1'b1 && pin === 1'b0, "no fast fault");
    cyc(150);
    kick_now();
    cyc(150);
    chk(foe === 1'b1, "fault pulse short");
    cyc(100);
    chk(foe === 1'b0 && pin === 1'b1, "fault pulse long");
    kick_now();
    cyc(40);
    chk(foe === 1'b0, "kick after fault faulted");
    cyc(39000);
    chk(foe === 1'b0, "slow fault early");
    for (int i = 0; i < 2000 && foe !== 1'b1; i++) cyc(1);
    chk(foe === 1'b1, "no slow fault");
    cyc(500);
  endtask : t_window
  task automatic t_mr;
    mr <= 1'b0;
    cyc(10);
    mr <= 1'b1;
    cyc(100);
    chk(srst_n === 1'b1, "glitch caused reset");
    kick_now();
    cyc(100);
    kick_now();
    cyc(200);
    mr <= 1'b0;
    cyc(200);
    chk(srst_n === 1'b0 && foe === 1'b0, "manual reset ignored");
    mr <= 1'b1;
    hold_chk();
  endtask : t_mr
  task automatic t_uv;
    uv <= 1'b1;
    cyc(100);
    chk(srst_n === 1'b0, "undervoltage ignored");
    uv <= 1'b0;
    cyc(300);
    uv <= 1'b1;
    cyc(10);
    uv <= 1'b0;
    hold_chk();
  endtask : t_uv

  initial begin
    reset_n = 1'b0;
    mr = 1'b1;
    uv = 1'b0;
    kreq = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cyc(2);
    reset_n <= 1'b1;
    hold_chk();
    t_window();
    t_mr();
    t_uv();
    report_and_stop();
  end

  // watchdog against a hang
  initial begin
    cyc(80000);
    bad_count++;
    $display("[ERR] %0t timeout", $time);
    report_and_stop();
  end
endmodule : wwds_supervisor_tb
